// ### design/drive_status_word_monitor.sv
// apb register bank that builds and reports the drive status word
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: bit 0 ready to switch on
// RULE_02: bit 1 switched on or ready
// RULE_03: bit 2 operation enabled, running
// RULE_04: bit 3 error, bit 7 warning
// RULE_05: bit 4 power stage supply present
// RULE_06: bit 5 low on quick stop, io one
// RULE_07: bit 6 switch-on disabled
// RULE_08: bits 0,1,2,3,5,6 encode drive state
// RULE_09: same numeric word in both profiles
// RULE_10: bit 9 network versus display source
// RULE_11: bit 10 target reference reached
// RULE_12: bit 11 reference outside speed limits
// RULE_13: bit 14 stop by keypad key
// RULE_14: bit 15 reverse output rotation
// RULE_15: read-only active reference channel
// RULE_16: option channels only with module inserted
// RULE_17: signed pre-ramp reference readable
// RULE_18: reference clamped to high speed, 599.0
// RULE_19: bits 8,12,13 zero; io 9,14,15 zero
module drive_status_word_monitor
    import drive_monitor_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [drive_monitor_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [6:0]                      drive_state,
    input  wire logic                            supply_present,
    input  wire logic                            warning_active,
    input  wire logic                            ref_reached,
    input  wire logic                            remote_source,
    input  wire logic                            stop_key_pressed,
    input  wire logic                            reverse_rotation,
    input  wire logic [2:0]                      requested_channel,
    input  wire logic                            canopen_inserted,
    input  wire logic                            fieldbus_inserted,
    input  wire logic signed [15:0]              raw_reference,
    output logic      [15:0]                     drive_status_word,
    output logic      [2:0]                      active_channel,
    output logic signed [15:0]                   pre_ramp_reference,
    output logic                                 irq
);
    import drive_monitor_pkg::*;

    // external condition inputs come from other domains
    logic [6:0]  state_s1, state_s2;
    logic [6:0]  flags_s1, flags_s2;
    logic [2:0]  chan_s1, chan_s2;
    logic [1:0]  opt_s1, opt_s2;
    logic [15:0] ref_s1, ref_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_s1 <= 7'h01;
            state_s2 <= 7'h01;
            flags_s1 <= 7'h00;
            flags_s2 <= 7'h00;
            chan_s1  <= 3'h0;
            chan_s2  <= 3'h0;
            opt_s1   <= 2'h0;
            opt_s2   <= 2'h0;
            ref_s1   <= 16'h0000;
            ref_s2   <= 16'h0000;
        end else begin
            state_s1 <= drive_state;
            state_s2 <= state_s1;
            flags_s1 <= {supply_present, warning_active, ref_reached, remote_source,
                         stop_key_pressed, reverse_rotation, 1'b0};
            flags_s2 <= flags_s1;
            chan_s1  <= requested_channel;
            chan_s2  <= chan_s1;
            opt_s1   <= {canopen_inserted, fieldbus_inserted};
            opt_s2   <= opt_s1;
            ref_s1   <= raw_reference;
            ref_s2   <= ref_s1;
        end
    end

    // a multi-bit word is taken only when two samples in a row agree, so a word
    // caught mid-change never reaches the status logic; costs one more edge
    logic [6:0]  state_q;
    logic [2:0]  chan_q;
    logic [15:0] ref_q;
    wire logic state_even = state_s1 == state_s2;
    wire logic chan_even  = chan_s1 == chan_s2;
    wire logic ref_even   = ref_s1 == ref_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= 7'h01;
            chan_q  <= 3'h0;
            ref_q   <= 16'h0000;
        end else begin
            if (state_even)
                state_q <= state_s2;
            if (chan_even)
                chan_q <= chan_s2;
            if (ref_even)
                ref_q <= ref_s2;
        end
    end

    wire logic sup_w    = flags_s2[6];
    wire logic warn_w   = flags_s2[5];
    wire logic reach_w  = flags_s2[4];
    wire logic remote_w = flags_s2[3];
    wire logic key_w    = flags_s2[2];
    wire logic rev_w    = flags_s2[1];

    // software-written registers and the read-to-clear interrupt status
    logic [15:0]     high_speed_limit;
    logic [15:0]     low_speed_limit;
    logic [1:0]      profile_select;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // apb decode; zero wait states
    wire logic access   = psel && penable;
    wire logic wr_en    = access && pwrite;
    wire logic rd_en    = access && !pwrite;
    wire logic hit_sw   = paddr == OFF_STATUS_WORD;
    wire logic hit_ch   = paddr == OFF_REF_CHANNEL;
    wire logic hit_pr   = paddr == OFF_PRE_RAMP;
    wire logic hit_hs   = paddr == OFF_HIGH_SPEED;
    wire logic hit_ls   = paddr == OFF_LOW_SPEED;
    wire logic hit_cfg  = paddr == OFF_CONFIG;
    wire logic hit_ist  = paddr == OFF_IRQ_STATUS;
    wire logic hit_imk  = paddr == OFF_IRQ_MASK;
    wire logic hit_ro   = hit_sw || hit_ch || hit_pr || hit_ist;
    wire logic hit_rw   = hit_hs || hit_ls || hit_cfg || hit_imk;
    wire logic mapped   = hit_ro || hit_rw;
    // writes to read-only or unmapped words are errored and ignored
    wire logic bad_acc  = !mapped || (pwrite && hit_ro);
    wire logic wr_ok    = wr_en && !bad_acc;

    assign pready  = 1'b1;
    assign pslverr = access && bad_acc;

    // high speed limit saturates at the overall range
    wire logic [15:0] hs_wdata = pwdata[15:0];
    wire logic [15:0] hs_clip  = ($signed(hs_wdata) > FREQ_ABS_MAX) ? FREQ_ABS_MAX
                               : ($signed(hs_wdata) < 16'sh0000) ? 16'h0000 : hs_wdata; // RULE_18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_speed_limit <= RST_HIGH_SPEED;
            low_speed_limit  <= RST_LOW_SPEED;
            profile_select   <= RST_PROFILE;
            irq_mask         <= RST_IRQ_MASK;
        end else if (wr_ok) begin
            if (hit_hs && pstrb[1:0] == 2'h3)
                high_speed_limit <= hs_clip;
            if (hit_ls && pstrb[1:0] == 2'h3)
                low_speed_limit <= pwdata[15:0];
            if (hit_cfg && pstrb[0])
                profile_select <= pwdata[CFG_PROFILE_LSB +: 2];
            if (hit_imk && pstrb[0])
                irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    // active channel; option channels fall back to terminals when absent
    wire logic chan_ok = !((chan_q == chan_canopen && !opt_s2[1])
                        || (chan_q == chan_fieldbus && !opt_s2[0])
                        || chan_q > chan_pc_tool);               // RULE_16
    wire logic [2:0] next_channel = chan_ok ? chan_q : chan_terminals; // RULE_15

    // clamp reference to +/- high speed limit
    wire logic signed [15:0] hs_pos = $signed(high_speed_limit);
    wire logic signed [15:0] hs_neg = -$signed(high_speed_limit);
    wire logic signed [15:0] ref_in = $signed(ref_q);
    wire logic signed [15:0] next_pre_ramp = (ref_in > hs_pos) ? hs_pos
                                           : (ref_in < hs_neg) ? hs_neg : ref_in; // RULE_18

    // limit check on magnitude against low and high speed
    wire logic [15:0] ref_mag   = ref_in[15] ? 16'(-ref_in) : 16'(ref_in);
    wire logic        out_limit = (ref_mag > high_speed_limit)
                               || (ref_mag < low_speed_limit && ref_mag != 16'h0000); // RULE_12

    // state decode
    wire logic in_fault  = state_q == st_fault;
    wire logic is_io     = profile_select == io_profile;

    logic [15:0] next_status;
    always_comb begin
        next_status = 16'h0000;                                   // RULE_19
        // state encoding identical in every profile except bit 5, which io profile holds at one
        case (state_q)                                            // RULE_08
            st_sw_on_disable: next_status[BIT_SW_ON_DIS] = 1'b1;  // RULE_07
            st_ready:         next_status[BIT_READY_SW_ON] = 1'b1; // RULE_01
            st_switched_on: begin
                next_status[BIT_READY_SW_ON] = 1'b1;
                next_status[BIT_SWITCHED_ON] = 1'b1;              // RULE_02
            end
            st_op_enabled: begin
                next_status[BIT_READY_SW_ON] = 1'b1;
                next_status[BIT_SWITCHED_ON] = 1'b1;
                next_status[BIT_OP_ENABLED]  = 1'b1;              // RULE_03
            end
            st_quick_stop: begin
                next_status[BIT_READY_SW_ON] = 1'b1;
                next_status[BIT_SWITCHED_ON] = 1'b1;
                next_status[BIT_OP_ENABLED]  = 1'b1;
            end
            st_fault: begin
                next_status[BIT_READY_SW_ON] = 1'b1;
                next_status[BIT_SWITCHED_ON] = 1'b1;
                next_status[BIT_OP_ENABLED]  = 1'b1;
            end
            default: next_status[BIT_READY_SW_ON] = 1'b0;
        endcase
        if (in_fault)
            next_status[BIT_OP_ENABLED] = 1'b0;
        next_status[BIT_ERROR]   = in_fault;                      // RULE_04
        next_status[BIT_WARNING] = warn_w;                        // RULE_04
        next_status[BIT_VOLTAGE] = sup_w;                         // RULE_05
        // quick stop low only in its own state; io profile reads one there too
        next_status[BIT_QUICK_STOP] = (state_q != st_quick_stop) || is_io; // RULE_06
        next_status[BIT_REF_REACHED] = reach_w;                   // RULE_11
        next_status[BIT_LIMIT]       = out_limit;                 // RULE_12
        // profile-specific bits stay zero in io profile
        if (!is_io) begin                                         // RULE_09
            next_status[BIT_REMOTE]    = remote_w;                // RULE_10
            next_status[BIT_STOP_KEY]  = key_w;                   // RULE_13
            next_status[BIT_DIRECTION] = rev_w;                   // RULE_14
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_status_word  <= 16'h0000;
            active_channel     <= 3'h0;
            pre_ramp_reference <= 16'sh0000;
        end else begin
            drive_status_word  <= next_status;
            active_channel     <= next_channel;
            pre_ramp_reference <= next_pre_ramp;                  // RULE_17
        end
    end

    // interrupt events: rising error, warning, limit; channel change
    wire logic [IRQ_W-1:0] events;
    assign events[IRQ_ERROR]   = next_status[BIT_ERROR]   && !drive_status_word[BIT_ERROR];
    assign events[IRQ_WARNING] = next_status[BIT_WARNING] && !drive_status_word[BIT_WARNING];
    assign events[IRQ_LIMIT]   = next_status[BIT_LIMIT]   && !drive_status_word[BIT_LIMIT];
    assign events[IRQ_CHANNEL] = next_channel != active_channel;

    // set wins over the read-to-clear in the same cycle
    wire logic ist_clear = rd_en && hit_ist;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_status <= '0;
        else
            irq_status <= (ist_clear ? '0 : irq_status) | events;
    end

    assign irq = |(irq_status & irq_mask);

    // read mux, flop contents driven to prdata through the mux with no output register
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_sw)  rd_mux[15:0] = drive_status_word;
        if (hit_ch)  rd_mux[2:0]  = active_channel;
        if (hit_pr)  rd_mux[15:0] = pre_ramp_reference;
        if (hit_hs)  rd_mux[15:0] = high_speed_limit;
        if (hit_ls)  rd_mux[15:0] = low_speed_limit;
        if (hit_cfg) rd_mux[1:0]  = profile_select;
        if (hit_ist) rd_mux[IRQ_W-1:0] = irq_status;
        if (hit_imk) rd_mux[IRQ_W-1:0] = irq_mask;
    end
    assign prdata = rd_en ? rd_mux : 32'h0000_0000;

endmodule : drive_status_word_monitor

// ### pkg/drive_monitor_pkg.sv
// register map, field positions and encodings of the drive status monitor
package drive_monitor_pkg;

    localparam int unsigned ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] OFF_STATUS_WORD = 12'h000;
    localparam logic [11:0] OFF_REF_CHANNEL = 12'h004;
    localparam logic [11:0] OFF_PRE_RAMP    = 12'h008;
    localparam logic [11:0] OFF_HIGH_SPEED  = 12'h00C;
    localparam logic [11:0] OFF_LOW_SPEED   = 12'h010;
    localparam logic [11:0] OFF_CONFIG      = 12'h014;
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h01C;

    // status word bit positions
    localparam int unsigned BIT_READY_SW_ON = 0;
    localparam int unsigned BIT_SWITCHED_ON = 1;
    localparam int unsigned BIT_OP_ENABLED  = 2;
    localparam int unsigned BIT_ERROR       = 3;
    localparam int unsigned BIT_VOLTAGE     = 4;
    localparam int unsigned BIT_QUICK_STOP  = 5;
    localparam int unsigned BIT_SW_ON_DIS   = 6;
    localparam int unsigned BIT_WARNING     = 7;
    localparam int unsigned BIT_REMOTE      = 9;
    localparam int unsigned BIT_REF_REACHED = 10;
    localparam int unsigned BIT_LIMIT       = 11;
    localparam int unsigned BIT_STOP_KEY    = 14;
    localparam int unsigned BIT_DIRECTION   = 15;

    // frequency in 0.1 Hz units, signed
    localparam int unsigned FREQ_W = 16;
    localparam logic signed [15:0] FREQ_ABS_MAX = 16'sh1766; // 599.0 Hz

    // reset values of the writable registers
    localparam logic [15:0] RST_HIGH_SPEED = 16'h01F4; // 50.0 Hz
    localparam logic [15:0] RST_LOW_SPEED  = 16'h0000;
    localparam logic [1:0]  RST_PROFILE    = 2'h0;
    localparam logic [3:0]  RST_IRQ_MASK   = 4'h0;

    // config register fields
    localparam int unsigned CFG_PROFILE_LSB = 0;

    // interrupt status bit positions
    localparam int unsigned IRQ_ERROR    = 0;
    localparam int unsigned IRQ_WARNING  = 1;
    localparam int unsigned IRQ_LIMIT    = 2;
    localparam int unsigned IRQ_CHANNEL  = 3;
    localparam int unsigned IRQ_W        = 4;

    typedef enum logic [1:0] {
        combined_profile = 2'h0,
        separate_profile = 2'h1,
        io_profile       = 2'h2
    } profile_select_t;

    typedef enum logic [2:0] {
        chan_terminals = 3'h0,
        chan_display   = 3'h1,
        chan_modbus    = 3'h2,
        chan_canopen   = 3'h3,
        chan_fieldbus  = 3'h4,
        chan_ethernet  = 3'h5,
        chan_pc_tool   = 3'h6
    } ref_channel_t;

    // drive state machine states, one-hot
    typedef enum logic [6:0] {
        st_not_ready     = 7'h01,
        st_sw_on_disable = 7'h02,
        st_ready         = 7'h04,
        st_switched_on   = 7'h08,
        st_op_enabled    = 7'h10,
        st_quick_stop    = 7'h20,
        st_fault         = 7'h40
    } drive_state_t;

endpackage : drive_monitor_pkg

// ### verif/word_rules_monitor.sv
// concurrent checks on the status monitor ports
`timescale 1ns/1ns
module word_rules_monitor
    import drive_monitor_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic               pslverr,
    input wire logic [6:0]         drive_state,
    input wire logic               supply_present,
    input wire logic               warning_active,
    input wire logic               canopen_inserted,
    input wire logic [15:0]        drive_status_word,
    input wire logic [2:0]         active_channel,
    input wire logic signed [15:0] pre_ramp_reference
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc;
    wire logic ro_hit;
    assign acc = psel && penable;
    assign ro_hit = paddr == OFF_STATUS_WORD || paddr == OFF_REF_CHANNEL || paddr == OFF_PRE_RAMP;
    // inputs cross two sync flops and an output flop, hence the window
    chk_supply_bit: assert property (
        $rose(supply_present) |-> ##[2:4] drive_status_word[4]) else $error("supply bit late");
    chk_warn_bit: assert property (
        $rose(warning_active) |-> ##[2:4] drive_status_word[7]) else $error("warning bit late");
    chk_fault_bit: assert property (
        (drive_state == st_fault)[*5] |-> drive_status_word[3]) else $error("error bit low");
    chk_disabled_code: assert property (
        (drive_state == st_sw_on_disable)[*5] |-> drive_status_word[6]
        && drive_status_word[2:0] == 3'h0) else $error("disabled code wrong");
    chk_reserved_zero: assert property (
        drive_status_word[13:12] == 2'h0 && !drive_status_word[8]) else $error("reserved bit set");
    chk_ref_clamp: assert property (
        pre_ramp_reference <= FREQ_ABS_MAX && pre_ramp_reference >= -FREQ_ABS_MAX)
        else $error("reference out of range");
    chk_channel_code: assert property (
        active_channel <= 3'h6) else $error("channel code invalid");
    chk_option_gate: assert property (
        (!canopen_inserted)[*5] |-> active_channel != chan_canopen) else $error("absent option");
    chk_ro_refused: assert property (
        acc && pwrite && ro_hit |-> pslverr) else $error("read-only write accepted");
    cover property ((drive_state == st_quick_stop)[*5]);
    cover property (acc && pslverr);
    cover property ($rose(warning_active));
endmodule : word_rules_monitor

bind drive_status_word_monitor word_rules_monitor u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pslverr, .drive_state, .supply_present, .warning_active,
    .canopen_inserted, .drive_status_word, .active_channel, .pre_ramp_reference);

// ### verif/apb_status_reader.sv
// apb master model standing in for the fieldbus reader
`timescale 1ns/1ns
module apb_status_reader (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    // an idle cycle between transfers; request held until pready is seen
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_status_reader

// ### verif/drive_status_word_monitor_tb.sv
// self-checking bench for the drive status word monitor
`timescale 1ns/1ns
module drive_status_word_monitor_tb;
    import drive_monitor_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic supply_present, warning_active, ref_reached, remote_source, stop_key_pressed;
    logic reverse_rotation, canopen_inserted, fieldbus_inserted;
    logic [6:0]         drive_state;
    logic [2:0]         requested_channel, active_channel;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rdat;
    logic [3:0]         pstrb;
    logic [15:0]        drive_status_word;
    logic signed [15:0] raw_reference, pre_ramp_reference;
    int                 err_count, n_checks;

    drive_status_word_monitor uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .drive_state, .supply_present,
        .warning_active, .ref_reached, .remote_source, .stop_key_pressed, .reverse_rotation,
        .requested_channel, .canopen_inserted, .fieldbus_inserted, .raw_reference,
        .drive_status_word, .active_channel, .pre_ramp_reference, .irq);
    apb_status_reader u_rd (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [11:0] a, input logic [31:0] exp);
        u_rd.xfer(1'b0, a, 32'h0, rdat, rerr);
        chk(rdat, exp);
    endtask : rd
    task wr(input logic [11:0] a, input logic [31:0] d);
        u_rd.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr
    // words need four edges to show (sync, agree, output flop); five leaves one spare
    task settle;
        repeat (5) @(posedge pclk);
    endtask : settle
    function automatic logic [15:0] exp_word(input logic [6:0] s, input logic io);
        logic [6:0] lo;
        case (s)
            st_sw_on_disable: lo = 7'h40;
            st_ready:         lo = 7'h01;
            st_switched_on:   lo = 7'h03;
            st_op_enabled:    lo = 7'h07;
            st_quick_stop:    lo = 7'h07;
            st_fault:         lo = 7'h0B;
            default:          lo = 7'h00;
        endcase
        lo[5] = io || (s != st_quick_stop);
        lo[4] = supply_present;
        return {reverse_rotation & ~io, stop_key_pressed & ~io, 3'h0, ref_reached,
                remote_source & ~io, 1'b0, warning_active, lo};
    endfunction : exp_word

    task t_states;
        for (int k = 0; k < 3; k++) begin
            wr(OFF_CONFIG, 32'(k));
            for (int i = 0; i < 7; i++) begin
                @(posedge pclk);
                drive_state <= 7'h01 << i;
                {supply_present, warning_active, remote_source, stop_key_pressed,
                 reverse_rotation, ref_reached} <= 6'(i * 11 + k * 7);
                settle();
                chk(drive_status_word, exp_word(drive_state, k == 2));
                rd(OFF_STATUS_WORD, {16'h0, exp_word(drive_state, k == 2)});
            end
        end
    endtask : t_states
    task ref_case(input logic signed [15:0] r, input logic signed [15:0] e, input logic l);
        @(posedge pclk);
        raw_reference <= r;
        settle();
        chk({16'h0, pre_ramp_reference}, {16'h0, e});
        chk({31'h0, drive_status_word[11]}, {31'h0, l});
        rd(OFF_PRE_RAMP, {16'h0, e});
    endtask : ref_case
    task t_ref;
        wr(OFF_HIGH_SPEED, 32'h64);
        wr(OFF_LOW_SPEED, 32'h0A);
        ref_case(16'sh00C8, 16'sh0064, 1'b1);
        ref_case(-16'sh00C8, -16'sh0064, 1'b1);
        ref_case(16'sh0032, 16'sh0032, 1'b0);
        ref_case(16'sh0005, 16'sh0005, 1'b1);
        wr(OFF_HIGH_SPEED, 32'h2000);
        rd(OFF_HIGH_SPEED, 32'h1766);
        ref_case(-16'sh7000, -16'sh1766, 1'b1);
        wr(OFF_PRE_RAMP, 32'h55);
        chk({31'h0, rerr}, 32'h1);
        rd(OFF_PRE_RAMP, 32'h0000E89A);
        wr(OFF_STATUS_WORD, 32'h1);
        chk({31'h0, rerr}, 32'h1);
        rd(12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask : t_ref
    task t_chan;
        logic [2:0] e;
        for (int c = 0; c < 7; c++) begin
            for (int ins = 0; ins < 2; ins++) begin
                @(posedge pclk);
                requested_channel <= 3'(c);
                canopen_inserted <= 1'(ins);
                fieldbus_inserted <= 1'(ins);
                settle();
                e = ((c == 3 || c == 4) && ins == 0) ? 3'h0 : 3'(c);
                chk({29'h0, active_channel}, {29'h0, e});
                rd(OFF_REF_CHANNEL, {29'h0, e});
            end
        end
        wr(OFF_REF_CHANNEL, 32'h2);
        chk({31'h0, rerr}, 32'h1);
    endtask : t_chan
    task t_irq;
        @(posedge pclk);
        warning_active <= 1'b0;
        settle();
        wr(OFF_IRQ_MASK, 32'h2);
        u_rd.xfer(1'b0, OFF_IRQ_STATUS, 32'h0, rdat, rerr);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        warning_active <= 1'b1;
        settle();
        chk({31'h0, irq}, 32'h1);
        rd(OFF_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h0);
        @(posedge pclk);
        warning_active <= 1'b0;
        settle();
        warning_active <= 1'b1;
        settle();
        chk({31'h0, irq}, 32'h0);
        rd(OFF_IRQ_STATUS, 32'h2);
        wr(OFF_IRQ_MASK, 32'h8);
        @(posedge pclk);
        requested_channel <= 3'h1;
        settle();
        chk({31'h0, irq}, 32'h1);
        rd(OFF_IRQ_STATUS, 32'h8);
    endtask : t_irq

    task test_done;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial begin
        err_count = 0;
        n_checks = 0;
        presetn = 1'b0;
        drive_state = 7'h01;
        {supply_present, warning_active, ref_reached, remote_source} = 4'h0;
        {stop_key_pressed, reverse_rotation, canopen_inserted, fieldbus_inserted} = 4'h0;
        requested_channel = 3'h0;
        raw_reference = 16'sh0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_HIGH_SPEED, 32'h1F4);
        rd(OFF_IRQ_MASK, 32'h0);
        t_states();
        t_ref();
        t_chan();
        t_irq();
        test_done();
    end
    initial begin
        #100000;
        err_count++;
        test_done();
    end
endmodule : drive_status_word_monitor_tb
